// *** hw/amrm_read_master.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "amrm_regs.svh"

// What this block does
// - Read strobe stays low for the programmed wait-state count of clock cycles (one for zero), longer while acknowledge is low.
// - Address and bank selects are valid one cycle before the strobe falls.
// - Address and selects stay stable for read-hold cycles after strobe rises.
// - Strobe rise to next fall spans read-hold plus idle cycles plus one.
// - Same-bank back-to-back reads without idle cycles are spaced one plus read-hold.
// - Reads to another bank use the same strobe-high to strobe-low gap.
// - A write may follow a read after max(5, idle count plus 1) cycles.
// - Strobe, acknowledge and data behaviour apply only in asynchronous access mode.
module amrm_read_master
   import amrm_pkg::*;
#(
   parameter int ADDR_W = 24,
   parameter int DATA_W = 8,
   parameter int BANK_W = 2
)
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // External memory pins.
   output logic [ADDR_W-1:0] memory_address_o,
   output logic [(1<<BANK_W)-1:0] memory_bank_select_n_o,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   input wire logic memory_acknowledge_i,
   input wire logic [DATA_W-1:0] memory_data_bus_i,
   output logic [DATA_W-1:0] memory_data_bus_o,
   output logic memory_data_bus_oe_o,
   // Read-to-write spacing met, for the write side.
   output logic write_allowed_o
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   amrm_sync_if ack_link ();
   amrm_state_type state;
   logic [31:0] async_memory_control;
   logic async_mode;
   logic [4:0] wait_cfg;
   logic [4:0] wait_eff;
   logic [2:0] read_hold_cycles;
   logic [2:0] idle_cycle_count;
   logic [3:0] gap_len;
   logic [3:0] rw_gap;
   logic pend_valid;
   logic [ADDR_W-1:0] pend_addr;
   logic [BANK_W-1:0] pend_bank;
   logic [BANK_W-1:0] bank;
   logic sel_active;
   logic [4:0] cnt;
   logic [3:0] rcnt;
   logic [7:0] since_rise;
   logic [DATA_W-1:0] read_data;
   logic done_flag;
   logic refused_flag;
   logic strobe_done;
   logic take;
   logic addr_wr;
   logic accept;

   // ------------------------------------------------------------------
   // Configuration decode
   // ------------------------------------------------------------------
   // Control fields; a zero wait count still gives a one-cycle strobe.
   assign async_mode = async_memory_control[`AMRM_CTRL_MODE_BIT];
   assign wait_cfg = async_memory_control[`AMRM_CTRL_WAIT_LSB +: `AMRM_CTRL_WAIT_W];
   assign read_hold_cycles = async_memory_control[`AMRM_CTRL_HOLD_LSB +: `AMRM_CTRL_HOLD_W];
   assign idle_cycle_count = async_memory_control[`AMRM_CTRL_IDLE_LSB +: `AMRM_CTRL_IDLE_W];
   assign wait_eff = (wait_cfg == 5'h00) ? 5'h01 : wait_cfg;
   assign gap_len = {1'b0, read_hold_cycles} + {1'b0, idle_cycle_count};
   // Read-to-write gap is 5 + (idle - 4), never below 5.
   assign rw_gap = ({1'b0, idle_cycle_count} > `AMRM_RD_WR_GAP_SUB)
      ? (`AMRM_RD_WR_GAP_MIN + {1'b0, idle_cycle_count} - `AMRM_RD_WR_GAP_SUB)
      : `AMRM_RD_WR_GAP_MIN;

   // ------------------------------------------------------------------
   // Acknowledge synchroniser
   // ------------------------------------------------------------------
   assign ack_link.ack_raw = memory_acknowledge_i;

   amrm_ack_sync u_ack_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .link(ack_link.sync)
   );

   // Access ends once the wait count is spent and acknowledge is high.
   assign strobe_done = (state == st_strobe) && (cnt == 5'h00) && ack_link.ack_sync;
   // A pending read launches from idle or straight after the recovery gap.
   assign take = pend_valid && async_mode && ((state == st_idle)
      || ((state == st_recov) && (rcnt == gap_len - 4'h1))
      || (strobe_done && (gap_len == 4'h0)));

   // ------------------------------------------------------------------
   // Read sequencer
   // ------------------------------------------------------------------
   // Steps setup, strobe, recovery; strobe is held while acknowledge is low.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state <= st_idle;
         cnt <= 5'h00;
         rcnt <= 4'h0;
         read_strobe_n_o <= 1'b1;
      end
      else if (take)
      begin
         state <= st_setup;
         read_strobe_n_o <= 1'b1;
      end
      else
      begin
         unique case (state)
            st_idle:
            begin
               read_strobe_n_o <= 1'b1;
            end
            st_setup:
            begin
               state <= st_strobe;
               cnt <= wait_eff - 5'h01;
               read_strobe_n_o <= 1'b0;
            end
            st_strobe:
            begin
               if (cnt != 5'h00)
               begin
                  cnt <= cnt - 5'h01;
               end
               else if (ack_link.ack_sync)
               begin
                  read_strobe_n_o <= 1'b1;
                  rcnt <= 4'h0;
                  state <= (gap_len == 4'h0) ? st_idle : st_recov;
               end
            end
            st_recov:
            begin
               rcnt <= rcnt + 4'h1;
               if (rcnt == gap_len - 4'h1)
               begin
                  state <= st_idle;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Address and bank selects
   // ------------------------------------------------------------------
   // Address is loaded at setup and held until the next setup.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         memory_address_o <= '0;
         bank <= '0;
         sel_active <= 1'b0;
      end
      else if (take)
      begin
         memory_address_o <= pend_addr;
         bank <= pend_bank;
         sel_active <= 1'b1;
      end
      else if ((strobe_done && (read_hold_cycles == 3'h0))
         || ((state == st_recov) && ({1'b0, rcnt} + 5'h01 >= {2'h0, read_hold_cycles})))
      begin
         sel_active <= 1'b0;
      end
   end

   // One active-low select per bank.
   for (genvar i = 0; i < (1 << BANK_W); i++)
   begin : g_sel
      always_ff @(posedge sys_clk_i)
      begin
         if (rst_i)
         begin
            memory_bank_select_n_o[i] <= 1'b1;
         end
         else
         begin
            memory_bank_select_n_o[i] <= !((take || (sel_active && !(
               (strobe_done && (read_hold_cycles == 3'h0))
               || ((state == st_recov)
               && ({1'b0, rcnt} + 5'h01 >= {2'h0, read_hold_cycles})))))
               && ((take ? pend_bank : bank) == BANK_W'(i)));
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data and read-to-write spacing
   // ------------------------------------------------------------------
   // Data is qualified by the strobe and taken in its last low cycle.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         read_data <= '0;
      end
      else if (strobe_done)
      begin
         read_data <= memory_data_bus_i;
      end
   end

   // Counts strobe-high cycles, saturating.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         since_rise <= 8'hFF;
      end
      else if (!read_strobe_n_o)
      begin
         since_rise <= 8'h00;
      end
      else if (since_rise != 8'hFF)
      begin
         since_rise <= since_rise + 8'h01;
      end
   end

   assign write_allowed_o = read_strobe_n_o && ((state == st_idle) || (state == st_recov))
      && (since_rise >= {4'h0, rw_gap});
   // This block never writes and never drives the data bus.
   assign write_strobe_n_o = 1'b1;
   assign memory_data_bus_o = '0;
   assign memory_data_bus_oe_o = 1'b0;

   // ------------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------------
   assign addr_wr = reg_wr_i && (reg_addr_i == `AMRM_OFS_ADDR);
   assign accept = addr_wr && async_mode && !pend_valid;

   // Control register, one pending request, sticky flags (set wins).
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         async_memory_control <= `AMRM_CTRL_RESET;
         pend_valid <= 1'b0;
         pend_addr <= '0;
         pend_bank <= '0;
         done_flag <= 1'b0;
         refused_flag <= 1'b0;
      end
      else
      begin
         if (reg_wr_i && (reg_addr_i == `AMRM_OFS_CTRL))
         begin
            async_memory_control <= reg_wdata_i;
         end
         if (accept)
         begin
            pend_valid <= 1'b1;
            pend_addr <= reg_wdata_i[ADDR_W-1:0];
            pend_bank <= reg_wdata_i[`AMRM_ADDR_BANK_LSB +: BANK_W];
         end
         else if (take)
         begin
            pend_valid <= 1'b0;
         end
         if (strobe_done)
         begin
            done_flag <= 1'b1;
         end
         else if (reg_wr_i && (reg_addr_i == `AMRM_OFS_STATUS)
            && reg_wdata_i[`AMRM_STAT_DONE_BIT])
         begin
            done_flag <= 1'b0;
         end
         if (addr_wr && !accept)
         begin
            refused_flag <= 1'b1;
         end
         else if (reg_wr_i && (reg_addr_i == `AMRM_OFS_STATUS)
            && reg_wdata_i[`AMRM_STAT_REFUSED_BIT])
         begin
            refused_flag <= 1'b0;
         end
      end
   end

   // Read data stands in the cycle after the read strobe only.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || !reg_rd_i)
      begin
         reg_rdata_o <= 32'h0000_0000;
      end
      else
      begin
         unique case (reg_addr_i)
            `AMRM_OFS_CTRL: reg_rdata_o <= async_memory_control;
            `AMRM_OFS_DATA: reg_rdata_o <= 32'(read_data);
            `AMRM_OFS_STATUS: reg_rdata_o <= {28'h0, write_allowed_o, refused_flag,
               done_flag, (state != st_idle) || pend_valid};
            default: reg_rdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   logic [7:0] low_len;
   logic seen_read;
   logic b2b;

   // Helper counters: strobe-low length, first read seen, back-to-back launch.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         low_len <= 8'h00;
         seen_read <= 1'b0;
         b2b <= 1'b0;
      end
      else
      begin
         low_len <= read_strobe_n_o ? 8'h00 : low_len + 8'h01;
         if (!read_strobe_n_o)
         begin
            seen_read <= 1'b1;
         end
         if (take)
         begin
            b2b <= (state != st_idle);
         end
      end
   end

   a_strobe_width: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(read_strobe_n_o) |-> (low_len >= {3'h0, wait_eff}))
      else $error("read strobe shorter than wait count");
   a_select_setup: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(read_strobe_n_o) |-> $stable(memory_bank_select_n_o) && $stable(memory_address_o)
      && (memory_bank_select_n_o != '1))
      else $error("selects not valid before strobe fell");
   a_address_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (seen_read && (state == st_recov) && (since_rise < {5'h0, read_hold_cycles}))
      |-> $stable(memory_address_o) && (memory_bank_select_n_o != '1))
      else $error("address or select released during hold");
   a_read_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ($fell(read_strobe_n_o) && seen_read) |-> (since_rise >= {4'h0, gap_len} + 8'h01))
      else $error("strobe high gap too short");
   a_back_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ($fell(read_strobe_n_o) && b2b) |-> (since_rise == {4'h0, gap_len} + 8'h01))
      else $error("back-to-back gap not exact");
   a_write_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      write_allowed_o |-> $past(read_strobe_n_o, 1) && $past(read_strobe_n_o, 2)
      && $past(read_strobe_n_o, 3) && $past(read_strobe_n_o, 4) && $past(read_strobe_n_o, 5))
      else $error("write allowed too soon after read");
   a_mode_refuse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (addr_wr && !async_mode) |=> refused_flag && (state != st_setup))
      else $error("request accepted outside async mode");
   a_ack_extend: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ((state == st_strobe) && !ack_link.ack_sync) |=> !read_strobe_n_o)
      else $error("strobe rose while acknowledge low");

   c_read_done: cover property (@(posedge sys_clk_i) disable iff (rst_i) strobe_done);
   c_ack_stretch: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == st_strobe) && (cnt == 5'h00) && !ack_link.ack_sync);
   c_back_to_back: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(read_strobe_n_o) && b2b);

endmodule

`default_nettype wire

// *** hw/amrm_regs.svh ***
`ifndef AMRM_REGS_SVH
`define AMRM_REGS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define AMRM_OFS_CTRL 8'h00
`define AMRM_OFS_ADDR 8'h04
`define AMRM_OFS_DATA 8'h08
`define AMRM_OFS_STATUS 8'h0C

// ------------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------------
`define AMRM_CTRL_MODE_BIT 0
`define AMRM_CTRL_WAIT_LSB 4
`define AMRM_CTRL_WAIT_W 5
`define AMRM_CTRL_HOLD_LSB 12
`define AMRM_CTRL_HOLD_W 3
`define AMRM_CTRL_IDLE_LSB 16
`define AMRM_CTRL_IDLE_W 3
`define AMRM_ADDR_BANK_LSB 24
`define AMRM_STAT_BUSY_BIT 0
`define AMRM_STAT_DONE_BIT 1
`define AMRM_STAT_REFUSED_BIT 2
`define AMRM_STAT_WRITE_OK_BIT 3

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define AMRM_CTRL_RESET 32'h0001_001F

// ------------------------------------------------------------------
// Timing counts in memory-interface clock cycles
// ------------------------------------------------------------------
`define AMRM_RD_WR_GAP_MIN 4'h5
`define AMRM_RD_WR_GAP_SUB 4'h4

`endif

// *** hw/amrm_pkg.sv ***
package amrm_pkg;

   // Read sequencer states, one-hot.
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_setup = 4'h2,
      st_strobe = 4'h4,
      st_recov = 4'h8
   } amrm_state_type;

endpackage

// *** hw/amrm_sync_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// Acknowledge pin on its way into the clock domain.
interface amrm_sync_if;
   logic ack_raw;
   logic ack_sync;
   modport sync (input ack_raw, output ack_sync);
   modport user (output ack_raw, input ack_sync);
endinterface

`default_nettype wire

// *** hw/amrm_ack_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for the memory acknowledge pin.
module amrm_ack_sync
   import amrm_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Pin and synchronised level.
   amrm_sync_if.sync link
);

   logic stage1;
   logic stage2;

   // The first stage feeds only the second; reset reads as acknowledged.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
      end
      else
      begin
         stage1 <= link.ack_raw;
         stage2 <= stage1;
      end
   end

   assign link.ack_sync = stage2;

endmodule

`default_nettype wire

// *** dv/amrm_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Static memory on the far side of the read master
// ------------------------------------------------------------------
module amrm_mem_model
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Memory pins.
   input wire logic [23:0] memory_address_i,
   input wire logic [3:0] memory_bank_select_n_i,
   input wire logic read_strobe_n_i,
   output logic memory_acknowledge_o,
   output logic [7:0] memory_data_bus_o,
   // Cycles of acknowledge low after the selects fall.
   input wire logic [3:0] stall_i
);
   logic [3:0] wait_cnt;
   logic prev_idle;
   logic [7:0] last_data;
   logic drive;

   // Acknowledge is pulled low when selected and released after the stall count.
   always_ff @(posedge sys_clk_i)
   begin
      prev_idle <= &memory_bank_select_n_i;
      if (rst_i)
         wait_cnt <= 4'h0;
      else if (prev_idle && !(&memory_bank_select_n_i))
         wait_cnt <= stall_i;
      else if (wait_cnt != 4'h0)
         wait_cnt <= wait_cnt - 4'h1;
   end
   assign memory_acknowledge_o = (wait_cnt == 4'h0);

   // Data stand only while strobe and select are low; otherwise the bus churns.
   always_ff @(posedge sys_clk_i)
   begin
      last_data <= memory_data_bus_o;
   end
   assign drive = !read_strobe_n_i && !(&memory_bank_select_n_i);
   assign memory_data_bus_o = drive ? (memory_address_i[7:0] ^ 8'h5A) : ~last_data;
endmodule

`default_nettype wire

// *** dv/tb_async_memory_read_master.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_async_memory_read_master;
   import amrm_pkg::*;
   logic sys_clk, rst, reg_wr, reg_rd, rd_n, wr_n, ack, oe, wa;
   logic [7:0] reg_addr, din, dout;
   logic [31:0] reg_wdata, reg_rdata;
   logic [23:0] mem_addr;
   logic [3:0] sel_n, stall, sel_meas;
   logic prev_rd_n = 1'b1, prev_wa = 1'b1, prev_idle = 1'b1;
   int bad_count, checks, nfalls;
   int lcnt, hcnt, scnt, w_meas, gap_meas, setup_meas, hold_meas, wa_meas;

   // ------------------------------------------------------------------
   // Design, memory and clock
   // ------------------------------------------------------------------
   amrm_read_master dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .memory_address_o(mem_addr), .memory_bank_select_n_o(sel_n), .read_strobe_n_o(rd_n),
      .write_strobe_n_o(wr_n), .memory_acknowledge_i(ack), .memory_data_bus_i(din),
      .memory_data_bus_o(dout), .memory_data_bus_oe_o(oe), .write_allowed_o(wa));
   amrm_mem_model mem_u (.sys_clk_i(sys_clk), .rst_i(rst), .memory_address_i(mem_addr),
      .memory_bank_select_n_i(sel_n), .read_strobe_n_i(rd_n), .memory_acknowledge_o(ack),
      .memory_data_bus_o(din), .stall_i(stall));

   // Free-running 50 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Pin monitor: counts strobe width, gaps, select setup and hold per access.
   always @(posedge sys_clk)
   begin
      if (!rd_n && prev_rd_n)
      begin
         gap_meas = hcnt;
         setup_meas = scnt;
         sel_meas = sel_n;
         nfalls++;
      end
      if (wa && !prev_wa)
         wa_meas = hcnt;
      if (rd_n && lcnt > 0)
         w_meas = lcnt;
      if (&sel_n && !prev_idle)
         hold_meas = scnt;
      lcnt = rd_n ? 0 : lcnt + 1;
      hcnt = rd_n ? hcnt + 1 : 0;
      scnt = (&sel_n || !rd_n) ? 0 : scnt + 1;
      prev_rd_n = rd_n;
      prev_wa = wa;
      prev_idle = &sel_n;
   end

   // ------------------------------------------------------------------
   // Bus tasks and helpers
   // ------------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("Counts: checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Compares one value and reports a mismatch.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle register write.
   task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read; data are taken in the following cycle.
   task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Control word: mode, wait states, read hold and idle cycles.
   function automatic logic [31:0] cfg(input logic [4:0] w, input logic [2:0] rh,
      input logic [2:0] idle, input logic m);
      return {13'h0000, idle, 1'b0, rh, 3'h0, w, 3'h0, m};
   endfunction

   // Polls status until idle with done set, clears done, lets the access settle.
   task automatic wait_done;
      logic [31:0] d;
      int i;
      d = 32'h0;
      for (i = 0; i < 300 && d[1:0] !== 2'b10; i++)
         reg_rd_t(8'h0C, d);
      if (d[1:0] !== 2'b10)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, d, 32'h2);
         stop_test();
      end
      reg_wr_t(8'h0C, 32'h00000002);
      repeat (16) @(posedge sys_clk);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Pin levels and control word after reset; unmapped read gives zero.
   task automatic t_reset;
      logic [31:0] d;
      @(posedge sys_clk);
      #1;
      chk({28'h0, rd_n, wr_n, oe, wa}, 32'h0000000D);
      chk({28'h0, sel_n}, 32'h0000000F);
      chk({24'h0, dout}, 32'h00000000);
      reg_rd_t(8'h00, d);
      chk(d, 32'h0001001F);
      reg_rd_t(8'h0C, d);
      chk(d, 32'h00000008);
      reg_rd_t(8'h10, d);
      chk(d, 32'h00000000);
   endtask

   // Single read: data, strobe width, setup, hold, bank and write spacing.
   task automatic t_read(input logic [4:0] w, input logic [2:0] rh, input logic [2:0] idle,
      input logic [1:0] bank, input logic [23:0] a);
      logic [31:0] d;
      wa_meas = -1;
      w_meas = -1;
      setup_meas = -1;
      hold_meas = -1;
      reg_wr_t(8'h00, cfg(w, rh, idle, 1'b1));
      reg_wr_t(8'h04, {6'h00, bank, a});
      wait_done();
      reg_rd_t(8'h08, d);
      chk(d, {24'h0, a[7:0] ^ 8'h5A});
      chk(32'(w_meas), (w == 5'h00) ? 32'h1 : 32'(w));
      chk(32'(setup_meas), 32'h1);
      chk(32'(hold_meas), 32'(rh));
      chk({28'h0, sel_meas}, {28'h0, ~(4'h1 << bank)});
      chk(32'(wa_meas), (idle > 3'h4) ? 32'(idle) + 32'h1 : 32'h5);
   endtask

   // Two queued reads: strobe rise to next fall gap.
   task automatic t_b2b(input logic [2:0] idle, input logic [1:0] b0, input logic [1:0] b1);
      logic [31:0] d;
      gap_meas = -1;
      reg_wr_t(8'h00, cfg(5'h02, 3'h2, idle, 1'b1));
      reg_wr_t(8'h04, {6'h00, b0, 24'h000011});
      reg_wr_t(8'h04, {6'h00, b1, 24'h000022});
      wait_done();
      reg_rd_t(8'h08, d);
      chk(d, 32'h00000078);
      chk(32'(gap_meas), 32'(idle) + 32'h3);
   endtask

   // Memory holds acknowledge low; the strobe must stretch.
   task automatic t_stretch;
      logic [31:0] d;
      w_meas = -1;
      stall <= 4'h8;
      reg_wr_t(8'h00, cfg(5'h04, 3'h1, 3'h0, 1'b1));
      reg_wr_t(8'h04, 32'h01000040);
      wait_done();
      reg_rd_t(8'h08, d);
      chk(d, 32'h0000001A);
      chk(32'(w_meas >= 8 && w_meas <= 14), 32'h1);
      stall <= 4'h0;
   endtask

   // Launch with asynchronous mode off is refused and moves no strobe.
   task automatic t_refuse;
      logic [31:0] d;
      int n;
      n = nfalls;
      reg_wr_t(8'h00, cfg(5'h02, 3'h1, 3'h0, 1'b0));
      reg_wr_t(8'h04, 32'h00000055);
      repeat (20) @(posedge sys_clk);
      reg_rd_t(8'h0C, d);
      chk(d & 32'h00000007, 32'h00000004);
      chk(32'(nfalls - n), 32'h0);
      reg_wr_t(8'h0C, 32'h00000004);
      reg_rd_t(8'h0C, d);
      chk(d & 32'h00000004, 32'h0);
   endtask

   // Main sequence.
   initial
   begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      stall = 4'h0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_read(5'h02, 3'h1, 3'h0, 2'h0, 24'h000123);
      t_read(5'h05, 3'h3, 3'h6, 2'h3, 24'hABCD81);
      t_read(5'h01, 3'h0, 3'h7, 2'h2, 24'h00003C);
      t_read(5'h00, 3'h7, 3'h0, 2'h1, 24'hFFFFFF);
      t_b2b(3'h0, 2'h1, 2'h1);
      t_b2b(3'h2, 2'h0, 2'h3);
      t_stretch();
      t_refuse();
      stop_test();
   end
endmodule

`default_nettype wire
